// ==== core/tcc_chan.sv ====
// One capture input: three-stage synchroniser, glitch filter, edge detector.
// Assumes the pin is asynchronous to clk_i.
`timescale 1ns/1ps
`default_nettype none
module tcc_chan #(
  parameter int FILT_LEN = tcc_pkg::TCC_FILT_CYCLES
) (
  // Clock and reset.
  input  wire logic                   clk_i,
  input  wire logic                   rst_n_i,
  // Pin and configuration.
  input  wire logic                   pin_i,
  input  wire tcc_pkg::tcc_chan_cfg_s cfg_i,
  // Selected edge seen, one-cycle pulse.
  output logic                        evt_o
);
  import tcc_pkg::*;

  // The run counter has four bits, and a length of one would be no filter.
  if (FILT_LEN < 2 || FILT_LEN > 15) begin : g_bad_filt
    $error("tcc_chan: FILT_LEN out of range");
  end

  typedef struct packed {
    logic [2:0] sync;
    logic       stable;
    logic       filt;
    logic [3:0] run_len;
    logic       prev;
    logic       evt;
  } tcc_chan_st_s;

  tcc_chan_st_s st_ff;
  tcc_chan_st_s nxt_st;

  // Stage 1 only feeds stage 2; the agreed level comes from stages 2 and 3.
  always_comb begin
    nxt_st      = st_ff;
    nxt_st.sync = {st_ff.sync[1:0], pin_i};
    if (st_ff.sync[1] == st_ff.sync[2]) begin
      nxt_st.stable = st_ff.sync[2];
    end
    // A new level must persist FILT_LEN cycles before it is believed.
    if (!cfg_i.filt_en) begin
      nxt_st.filt    = st_ff.stable;
      nxt_st.run_len = 4'h0;
    end else if (st_ff.stable == st_ff.filt) begin
      nxt_st.run_len = 4'h0;
    end else if (st_ff.run_len == 4'(FILT_LEN - 1)) begin
      nxt_st.filt    = st_ff.stable;
      nxt_st.run_len = 4'h0;
    end else begin
      nxt_st.run_len = st_ff.run_len + 4'h1;
    end
    nxt_st.prev = st_ff.filt;
    case (cfg_i.edge_sel)
      TCC_EDGE_RISE: nxt_st.evt = st_ff.filt & ~st_ff.prev;
      TCC_EDGE_FALL: nxt_st.evt = ~st_ff.filt & st_ff.prev;
      TCC_EDGE_ANY:  nxt_st.evt = st_ff.filt ^ st_ff.prev;
      default:       nxt_st.evt = 1'b0;
    endcase
  end

  // State register.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign evt_o = st_ff.evt;

endmodule // tcc_chan
`default_nettype wire

// ==== core/tcc_top.sv ====
// Timer with three-channel input capture and compare, Avalon-MM slave.
// Assumes a single 40 MHz clock and capture pins asynchronous to it.
`timescale 1ns/1ps
`default_nettype none
module tcc_top #(
  parameter int NCHAN    = 3,
  parameter int FILT_LEN = tcc_pkg::TCC_FILT_CYCLES
) (
  // Clock and reset.
  input  wire logic                  clk_i,
  input  wire logic                  rst_n_i,
  // Avalon-MM slave.
  input  wire logic [7:0]            avs_address_i,
  input  wire logic                  avs_read_i,
  input  wire logic                  avs_write_i,
  input  wire logic [31:0]           avs_writedata_i,
  output logic [31:0]                avs_readdata_o,
  output logic                       avs_waitrequest_o,
  // Capture pins.
  input  wire logic [NCHAN-1:0]      capture_pins_i,
  // Interrupt requests towards the interrupt controller.
  output logic                       timer_irq_o,
  output logic                       capture_irq_o
);
  import tcc_pkg::*;

  // The reload trigger select names channels one to three, nothing more.
  if (NCHAN != 3) begin : g_bad_nchan
    $error("tcc_top: reload trigger select serves exactly three channels");
  end

  // Divide ratio minus one for a prescaler code. A table is used rather than
  // a shift because the ratios do not form a clean power series.
  function automatic logic [8:0] div_limit(input logic [2:0] code);
    case (code)
      3'd0:    div_limit = 9'd0;
      3'd1:    div_limit = 9'd3;
      3'd2:    div_limit = 9'd15;
      3'd3:    div_limit = 9'd31;
      3'd4:    div_limit = 9'd63;
      3'd5:    div_limit = 9'd127;
      3'd6:    div_limit = 9'd255;
      default: div_limit = 9'd511;
    endcase
  endfunction

  // Whole state of the block. Control bits keep their own fields rather than
  // a raw byte, so reserved bits are never stored and always read as zero.
  // The ack bit is the single wait state of the bus; rdata holds read data
  // from the edge that takes a read until the next read is taken.
  typedef struct packed {
    logic                   flag;
    logic                   run;
    logic                   mode;
    logic [7:0]             mode_reg;
    logic [15:0]            rcmp;
    logic [15:0]            cnt;
    logic [8:0]             presc;
    logic [NCHAN-1:0]       cap_en;
    logic [NCHAN-1:0]       cap_flag;
    logic [2*NCHAN-1:0]     edge_cfg;
    logic [NCHAN-1:0]       filt_en;
    logic [NCHAN-1:0][15:0] cap;
    logic                   ie_ea;
    logic                   ie_capture_interrupt_enable;
    logic                   ie_etmr;
    logic                   ack;
    logic [31:0]            rdata;
  } tcc_state_s;

  // Registered state, its next value, the bus request and channel wiring.
  tcc_state_s       st_ff;
  tcc_state_s       nxt_st;
  tcc_avm_req_s     req;
  tcc_chan_cfg_s    chan_cfg [NCHAN];
  logic [NCHAN-1:0] chan_evt;
  logic [NCHAN-1:0] cap_evt;

  // The bus pins are gathered into one request group for the decode below.
  assign req = '{address:   avs_address_i,
                 read:      avs_read_i,
                 write:     avs_write_i,
                 writedata: avs_writedata_i};

  // One channel block per capture pin.
  // Each channel owns its synchroniser and filter, so a noisy pin cannot
  // disturb the timing of its neighbours.
  genvar gi;
  generate
    for (gi = 0; gi < NCHAN; gi++) begin : g_chan
      assign chan_cfg[gi] = '{st_ff.filt_en[gi],
                              tcc_edge_e'(st_ff.edge_cfg[2*gi +: 2])};
      tcc_chan #(
        .FILT_LEN (FILT_LEN)
      ) u_chan (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .pin_i   (capture_pins_i[gi]),
        .cfg_i   (chan_cfg[gi]),
        .evt_o   (chan_evt[gi])
      );
    end
  endgenerate

  // A channel that software has not enabled is simply ignored.
  // Masking here keeps a disabled channel from reloading or clearing too.
  assign cap_evt = chan_evt & st_ff.cap_en;

  // Counter, flags, capture and register file in one next-state process.
  always_comb begin
    // Per-cycle events and decode helpers; all are given values just below.
    logic        tick;
    logic        ovf;
    logic        match;
    logic        reload_evt;
    logic        capclr;
    logic        wr;
    logic [7:0]  wb;
    logic [31:0] rd;
    logic [1:0]  trig;
    tick       = 1'b0;
    ovf        = 1'b0;
    match      = 1'b0;
    reload_evt = 1'b0;
    capclr     = 1'b0;
    wr         = 1'b0;
    wb         = req.writedata[7:0];
    rd         = TCC_RD_ZERO;
    trig       = st_ff.mode_reg[TCC_MODE_TRIG_LO +: 2];
    nxt_st     = st_ff;

    // Prescaler runs only with the run bit so a stop freezes the prescaler and ticks.
    // A divider change mid-period acts at once, since the test is >=.
    if (st_ff.run) begin
      if (st_ff.presc >= div_limit(st_ff.mode_reg[TCC_MODE_DIV_LO +: 3])) begin
        nxt_st.presc = 9'd0;
        tick         = 1'b1;
      end else begin
        nxt_st.presc = st_ff.presc + 9'd1;
      end
    end
    ovf   = tick && (st_ff.cnt == TCC_CNT_MAX);
    match = tick && st_ff.mode && (st_ff.cnt == st_ff.rcmp);

    // Counting step; overflow wraps through the natural 16-bit sum.
    // A compare match is found on the tick that leaves the compare value.
    if (tick) begin
      nxt_st.cnt = st_ff.cnt + 16'h0001;
    end
    if (match && st_ff.mode_reg[TCC_MODE_CMPCLR]) begin
      nxt_st.cnt = TCC_CNT_ZERO;
    end

    // Reload event select and auto-clear in reload mode.
    // Capture auto-clear outranks reload, so a period count starts at zero.
    // In compare mode neither reload nor capture clear has any effect.
    if (!st_ff.mode) begin
      if (trig == TCC_TRIG_OVF) begin
        reload_evt = ovf;
      end else begin
        reload_evt = cap_evt[trig - 2'd1];
      end
      capclr = st_ff.mode_reg[TCC_MODE_CAPCLR] && (cap_evt != '0);
      if (capclr) begin
        nxt_st.cnt = TCC_CNT_ZERO;
      end else if (reload_evt && st_ff.mode_reg[TCC_MODE_RELOAD_ENABLE_BIT]) begin
        nxt_st.cnt = st_ff.rcmp;
      end
    end

    // Capture stores the count before any clear of this cycle.
    // Several channels may capture in one cycle; each keeps its own copy.
    for (int i = 0; i < NCHAN; i++) begin
      if (cap_evt[i]) begin
        nxt_st.cap[i] = st_ff.cnt;
      end
    end

    // Bus: one wait state; writes act on the edge that ends the request.
    // A write to a count byte lands after the counting step above, so
    // software wins over hardware for that byte; the other byte still counts.
    nxt_st.ack = (req.read || req.write) && !st_ff.ack;
    wr         = req.write && st_ff.ack;
    if (wr) begin
      case (req.address)
        TCC_IDX_CTRL: begin
          nxt_st.flag = wb[TCC_CTRL_FLAG];
          nxt_st.run  = wb[TCC_CTRL_RUN];
          nxt_st.mode = wb[TCC_CTRL_MODE];
        end
        TCC_IDX_MODE:     nxt_st.mode_reg   = wb;
        TCC_IDX_RCMP_LO:  nxt_st.rcmp[7:0]  = wb;
        TCC_IDX_RCMP_HI:  nxt_st.rcmp[15:8] = wb;
        // Byte writes can tear against a running count.
        TCC_IDX_CNT_LO:   nxt_st.cnt[7:0]   = wb;
        TCC_IDX_CNT_HI:   nxt_st.cnt[15:8]  = wb;
        TCC_IDX_CAP_CTL0: begin
          nxt_st.cap_en   = wb[TCC_CAP_EN_LO +: NCHAN];
          nxt_st.cap_flag = wb[NCHAN-1:0];
        end
        TCC_IDX_CAP_EDGE: nxt_st.edge_cfg = wb[2*NCHAN-1:0];
        TCC_IDX_CAP_CTL2: nxt_st.filt_en  = wb[TCC_FILT_EN_LO +: NCHAN];
        TCC_IDX_INT_EN: begin
          nxt_st.ie_ea   = wb[TCC_IE_EA];
          nxt_st.ie_capture_interrupt_enable = wb[TCC_IE_CAPTURE_INTERRUPT_ENABLE];
          nxt_st.ie_etmr = wb[TCC_IE_ETMR];
        end
        default: begin
        end
      endcase
    end

    // Hardware sets win over a software clear in the same cycle.
    // Software may also set a flag by writing a one, which eases testing.
    if (ovf || match) begin
      nxt_st.flag = 1'b1;
    end
    nxt_st.cap_flag = nxt_st.cap_flag | cap_evt;

    // Read data, latched on the first edge of a read; unmapped reads zero.
    // Reserved bit positions keep the zero that rd starts with.
    case (req.address)
      TCC_IDX_CTRL: begin
        rd[TCC_CTRL_FLAG] = st_ff.flag;
        rd[TCC_CTRL_RUN]  = st_ff.run;
        rd[TCC_CTRL_MODE] = st_ff.mode;
      end
      TCC_IDX_MODE:     rd[7:0] = st_ff.mode_reg;
      TCC_IDX_RCMP_LO:  rd[7:0] = st_ff.rcmp[7:0];
      TCC_IDX_RCMP_HI:  rd[7:0] = st_ff.rcmp[15:8];
      TCC_IDX_CNT_LO:   rd[7:0] = st_ff.cnt[7:0];
      TCC_IDX_CNT_HI:   rd[7:0] = st_ff.cnt[15:8];
      TCC_IDX_CAP_CTL0: begin
        rd[TCC_CAP_EN_LO +: NCHAN] = st_ff.cap_en;
        rd[NCHAN-1:0]              = st_ff.cap_flag;
      end
      TCC_IDX_CAP_EDGE: rd[2*NCHAN-1:0] = st_ff.edge_cfg;
      TCC_IDX_CAP_CTL2: rd[TCC_FILT_EN_LO +: NCHAN] = st_ff.filt_en;
      TCC_IDX_INT_EN: begin
        rd[TCC_IE_EA]   = st_ff.ie_ea;
        rd[TCC_IE_CAPTURE_INTERRUPT_ENABLE] = st_ff.ie_capture_interrupt_enable;
        rd[TCC_IE_ETMR] = st_ff.ie_etmr;
      end
      default: begin
        for (int i = 0; i < NCHAN; i++) begin
          if (req.address == TCC_IDX_CAP_BASE + 8'(2*i)) begin
            rd[7:0] = st_ff.cap[i][7:0];
          end
          if (req.address == TCC_IDX_CAP_BASE + 8'(2*i + 1)) begin
            rd[7:0] = st_ff.cap[i][15:8];
          end
        end
      end
    endcase
    if (req.read && !st_ff.ack) begin
      nxt_st.rdata = rd;
    end
  end

  // State register; everything clears on reset.
  // Control clears too, so the counter always starts stopped.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Outputs. Waitrequest is combinational so the first cycle of a request
  // is held off at once. Interrupt requests are levels built from registered
  // flags and enables, so they drop the cycle after software clears a flag.
  assign avs_readdata_o    = st_ff.rdata;
  assign avs_waitrequest_o = (req.read || req.write) && !st_ff.ack;
  assign timer_irq_o       = st_ff.flag && st_ff.ie_etmr && st_ff.ie_ea;
  assign capture_irq_o     = (st_ff.cap_flag != '0) && st_ff.ie_capture_interrupt_enable
                             && st_ff.ie_ea;

endmodule // tcc_top
`default_nettype wire

// ==== inc/tcc_pkg.sv ====
// Shared constants and types of the timer with capture/compare unit.
// Assumes a word-addressed Avalon-MM slave whose address is a register index.
package tcc_pkg;

  // Register indices; the byte address of each is four times its index.
  localparam logic [7:0] TCC_IDX_CTRL     = 8'hc8;
  localparam logic [7:0] TCC_IDX_MODE     = 8'hc9;
  localparam logic [7:0] TCC_IDX_RCMP_LO  = 8'hca;
  localparam logic [7:0] TCC_IDX_RCMP_HI  = 8'hcb;
  localparam logic [7:0] TCC_IDX_CNT_LO   = 8'hcc;
  localparam logic [7:0] TCC_IDX_CNT_HI   = 8'hcd;
  localparam logic [7:0] TCC_IDX_CAP_CTL0 = 8'h92;
  localparam logic [7:0] TCC_IDX_CAP_EDGE = 8'h93;
  localparam logic [7:0] TCC_IDX_CAP_CTL2 = 8'h94;
  localparam logic [7:0] TCC_IDX_INT_EN   = 8'h9b;
  localparam logic [7:0] TCC_IDX_CAP_BASE = 8'he0;

  // Field positions.
  localparam int TCC_CTRL_FLAG    = 7;
  localparam int TCC_CTRL_RUN     = 2;
  localparam int TCC_CTRL_MODE    = 0;
  localparam int TCC_MODE_RELOAD_ENABLE_BIT    = 7;
  localparam int TCC_MODE_DIV_LO  = 4;
  localparam int TCC_MODE_CAPCLR  = 3;
  localparam int TCC_MODE_CMPCLR  = 2;
  localparam int TCC_MODE_TRIG_LO = 0;
  localparam int TCC_CAP_EN_LO    = 4;
  localparam int TCC_FILT_EN_LO   = 4;
  localparam int TCC_IE_EA        = 7;
  localparam int TCC_IE_CAPTURE_INTERRUPT_ENABLE      = 2;
  localparam int TCC_IE_ETMR      = 1;

  // Values after reset and fixed values.
  localparam logic [7:0]  TCC_RST_BYTE = 8'h00;
  localparam logic [15:0] TCC_CNT_ZERO = 16'h0000;
  localparam logic [15:0] TCC_CNT_MAX  = 16'hffff;
  localparam logic [31:0] TCC_RD_ZERO  = 32'h0000_0000;

  // Consecutive cycles a new input level must hold to pass the filter.
  localparam int TCC_FILT_CYCLES = 4;

  // Reload trigger encodings.
  localparam logic [1:0] TCC_TRIG_OVF = 2'h0;

  // Edge selection of one capture channel.
  typedef enum logic [1:0] {
    TCC_EDGE_RISE,
    TCC_EDGE_FALL,
    TCC_EDGE_ANY,
    TCC_EDGE_NONE
  } tcc_edge_e;

  // Configuration handed to one capture channel.
  typedef struct packed {
    logic      filt_en;
    tcc_edge_e edge_sel;
  } tcc_chan_cfg_s;

  // Avalon-MM request group.
  typedef struct packed {
    logic [7:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
  } tcc_avm_req_s;

endpackage : tcc_pkg

// ==== tb/tcc_checker.sv ====
// Concurrent checks on the ports of the timer with capture and compare.
// Assumes one clock domain and the asynchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module tcc_checker #(
  parameter int NCHAN = 3
) (
  // Clock, reset and bus.
  input wire logic             clk_i,
  input wire logic             rst_n_i,
  input wire logic [7:0]       avs_address_i,
  input wire logic             avs_read_i,
  input wire logic             avs_write_i,
  input wire logic [31:0]      avs_readdata_o,
  input wire logic             avs_waitrequest_o,
  // Pins and requests.
  input wire logic [NCHAN-1:0] capture_pins_i,
  input wire logic             timer_irq_o,
  input wire logic             capture_irq_o
);
  import tcc_pkg::*;
  logic [NCHAN-1:0] pins_ff;
  logic [4:0]       quiet_ff;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // Cycles since a pin moved; saturates so a long quiet spell never wraps.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pins_ff  <= '0;
      quiet_ff <= 5'h1f;
    end else begin
      pins_ff  <= capture_pins_i;
      quiet_ff <= (pins_ff != capture_pins_i) ? 5'h00 :
                  (quiet_ff == 5'h1f) ? quiet_ff : quiet_ff + 5'h01;
    end
  end
  // Bus answer, read data and interrupt request relations.
  property p_wait;
    $rose(avs_read_i || avs_write_i) |->
      avs_waitrequest_o ##1 !avs_waitrequest_o;
  endproperty
  a_wait: assert property (p_wait) else $error("no single wait state");
  property p_idle;
    !(avs_read_i || avs_write_i) |-> !avs_waitrequest_o;
  endproperty
  a_idle: assert property (p_idle) else $error("wait while idle");
  property p_rdhi;
    avs_read_i && !avs_waitrequest_o |-> avs_readdata_o[31:8] == 24'h0;
  endproperty
  a_rdhi: assert property (p_rdhi) else $error("upper read bits set");
  property p_hold;
    !avs_read_i |=> $stable(avs_readdata_o);
  endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_unmap;
    avs_read_i && !avs_waitrequest_o && !(avs_address_i inside
      {[8'hc8:8'hcd], [8'h92:8'h94], 8'h9b, [8'he0:8'he5]})
      |-> avs_readdata_o == TCC_RD_ZERO;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not 0");
  property p_capfell;
    $fell(capture_irq_o) |-> $past(avs_write_i);
  endproperty
  a_capfell: assert property (p_capfell) else $error("cap flag lost");
  property p_tmrfell;
    $fell(timer_irq_o) |-> $past(avs_write_i);
  endproperty
  a_tmrfell: assert property (p_tmrfell) else $error("tmr flag lost");
  property p_caprose;
    $rose(capture_irq_o) |-> $past(avs_write_i) || quiet_ff < 5'd16;
  endproperty
  a_caprose: assert property (p_caprose) else $error("capture no edge");
  c_wait: cover property (avs_read_i && !avs_waitrequest_o);
  c_cap: cover property ($rose(capture_irq_o));
  c_tmr: cover property ($rose(timer_irq_o));
endmodule // tcc_checker
bind tcc_top tcc_checker #(.NCHAN(NCHAN)) u_chk (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
  .capture_pins_i(capture_pins_i), .timer_irq_o(timer_irq_o),
  .capture_irq_o(capture_irq_o));
`default_nettype wire

// ==== tb/tcc_pin_model.sv ====
// Outside pulse source on the three capture pins.
// Assumes the bench calls pulse right after a rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module tcc_pin_model (
  // Clock.
  input  wire logic  clk_i,
  // Capture pins, idle low.
  output logic [2:0] pins_o
);
  initial pins_o = 3'h0;
  // High for len cycles, then quiet long enough for sync and filter to land.
  task automatic pulse(input int ch, input int len);
    pins_o[ch] <= 1'b1;
    repeat (len) @(posedge clk_i);
    pins_o[ch] <= 1'b0;
    repeat (16) @(posedge clk_i);
  endtask
endmodule // tcc_pin_model
`default_nettype wire

// ==== tb/tcc_tb_top.sv ====
// Self-checking bench for the timer with capture and compare.
// Assumes the checker is bound in and the pin model drives the pins.
`timescale 1ns/1ps
`default_nettype none
module timer_capture_compare_unit_tb_top;
  import tcc_pkg::*;
  logic         clk_i = 1'b0;
  logic         rst_n_i = 1'b0;
  tcc_avm_req_s req = '0;
  logic [31:0]  rdata;
  logic         wreq, tirq, cirq;
  logic [2:0]   pins;
  int           failures = 0, checks = 0, cyc = 0;
  logic [31:0]  seed = 32'h0000_cd79;
  logic [15:0]  v, p, k;
  logic [7:0]   b;
  logic [7:0]   regs[17] = '{8'hc8, 8'hc9, 8'hca, 8'hcb, 8'hcc, 8'hcd, 8'h92,
    8'h93, 8'h94, 8'h9b, 8'he0, 8'he1, 8'he2, 8'he3, 8'he4, 8'he5, 8'h10};
  int te[6] = '{3, 0, 0, 0, 1, 2};
  int tn[6] = '{1, 0, 1, 1, 1, 1};
  int tf[6] = '{0, 0, 1, 1, 0, 0};
  int tl[6] = '{6, 6, 3, 4, 6, 6};
  logic tx[6] = '{0, 0, 0, 1, 1, 1};
  always #12.5 clk_i = ~clk_i;
  tcc_top dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .avs_address_i(req.address),
    .avs_read_i(req.read), .avs_write_i(req.write),
    .avs_writedata_i(req.writedata), .avs_readdata_o(rdata),
    .avs_waitrequest_o(wreq), .capture_pins_i(pins),
    .timer_irq_o(tirq), .capture_irq_o(cirq));
  tcc_pin_model m (.clk_i(clk_i), .pins_o(pins));
  // A hang is cut short; a run out of cycles counts against the design.
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 80000) begin
      failures++;
      test_done();
    end
  end
  task automatic test_done();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // One bus cycle: held until waitrequest is sampled low at a rising edge;
  // read data is taken and the request released at that same edge. The
  // opening edge keeps one idle cycle between two calls.
  task automatic xfer(input logic [7:0] a, input logic w, input logic [7:0] d,
                      output logic [7:0] q);
    @(posedge clk_i);
    req <= '{a, ~w, w, {24'h0, d}};
    do @(posedge clk_i); while (wreq !== 1'b0);
    q = rdata[7:0];
    req <= '0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    xfer(a, 1'b1, d, q);
  endtask
  // Sixteen-bit values go as two byte accesses, low byte first.
  task automatic wr16(input logic [7:0] a, input logic [15:0] d);
    wr(a, d[7:0]);
    wr(a + 8'h01, d[15:8]);
  endtask
  task automatic rd16(input logic [7:0] a, output logic [15:0] q);
    xfer(a, 1'b0, 8'h00, q[7:0]);
    xfer(a + 8'h01, 1'b0, 8'h00, q[15:8]);
  endtask
  task automatic chk(input string n, input logic [15:0] lo,
                     input logic [15:0] hi, input logic [15:0] s);
    checks++;
    if ((s >= lo && s <= hi) !== 1'b1) begin
      $display("MISMATCH %s expected %h..%h seen %h", n, lo, hi, s);
      failures++;
    end
  endtask
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  function automatic int div_of(input int c);
    return (c == 0) ? 1 : (c == 1) ? 4 : 1 << (c + 2);
  endfunction
  initial begin
    repeat (3) @(posedge clk_i);
    rst_n_i <= 1'b1;
    // Reset values, an ignored unmapped write and the reserved control bits.
    wr(8'h10, 8'haa);
    foreach (regs[i]) begin
      xfer(regs[i], 1'b0, 8'h00, b);
      chk("reset", 16'h0, 16'h0, {8'h0, b});
    end
    wr(8'hc8, 8'hff);
    xfer(8'hc8, 1'b0, 8'h00, b);
    chk("ctrl", 16'h85, 16'h85, {8'h0, b});
    wr(8'hc8, 8'h00);
    // Every divider code: about twenty ticks, then the stopped count holds.
    for (int c = 0; c < 8; c++) begin
      wr(8'hc9, 8'(c << 4));
      wr16(8'hcc, 16'h0000);
      wr(8'hc8, 8'h04);
      repeat (20 * div_of(c)) @(posedge clk_i);
      wr(8'hc8, 8'h00);
      rd16(8'hcc, v);
      chk("count", 16'd19, 16'd24, v);
      repeat (40) @(posedge clk_i);
      rd16(8'hcc, k);
      chk("held", v, v, k);
    end
    // Compare with auto-clear at a random value; software clears the flag.
    seed = xs(seed);
    p = {11'h0, seed[4:0]} + 16'd16;
    wr(8'hc9, 8'h04);
    wr16(8'hca, p);
    wr16(8'hcc, 16'h0000);
    wr(8'h9b, 8'h82);
    wr(8'hc8, 8'h05);
    repeat (p + 6) @(posedge clk_i);
    @(negedge clk_i);
    chk("cmp_irq", 16'h1, 16'h1, {15'h0, tirq});
    wr(8'hc8, 8'h81);
    rd16(8'hcc, v);
    chk("cmp_clr", 16'd1, 16'd12, v);
    wr(8'hc8, 8'h00);
    @(negedge clk_i);
    chk("tmr_clr", 16'h0, 16'h0, {15'h0, tirq});
    // Overflow wraps to zero, or restarts at the reload value when enabled.
    for (int ld = 0; ld < 2; ld++) begin
      wr(8'hc9, ld ? 8'h80 : 8'h00);
      wr16(8'hca, 16'hff00);
      wr16(8'hcc, 16'hfff8);
      wr(8'hc8, 8'h04);
      repeat (20) @(posedge clk_i);
      @(negedge clk_i);
      chk("ovf_irq", 16'h1, 16'h1, {15'h0, tirq});
      wr(8'hc8, 8'h00);
      rd16(8'hcc, v);
      k = ld ? 16'hff00 : 16'h0000;
      chk("wrap", k + 16'd10, k + 16'd18, v);
    end
    // Capture on each trigger select, then capture auto-clear on channel 0.
    wr(8'h93, 8'h00);
    wr(8'h92, 8'h70);
    wr(8'h9b, 8'h84);
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      p = seed[15:0] & 16'h3fff;
      wr(8'hc9, (i < 3) ? 8'hf0 | 8'(i + 1) : 8'hf8);
      wr16(8'hca, 16'h4000);
      wr16(8'hcc, p);
      wr(8'hc8, 8'h04);
      m.pulse(i % 3, 6);
      @(negedge clk_i);
      chk("cap_irq", 16'h1, 16'h1, {15'h0, cirq});
      wr(8'hc8, 8'h00);
      rd16(8'he0 + 8'(2 * (i % 3)), v);
      chk("cap_val", p, p + 16'd1, v);
      rd16(8'hcc, v);
      k = (i < 3) ? 16'h4000 : 16'h0000;
      chk("after", k, k + 16'd1, v);
      xfer(8'h92, 1'b0, 8'h00, b);
      k = 16'h70 | (16'h1 << (i % 3));
      chk("flags", k, k, {8'h0, b});
      wr(8'h9b, 8'h04);
      @(negedge clk_i);
      chk("cap_ea", 16'h0, 16'h0, {15'h0, cirq});
      wr(8'h9b, 8'h84);
      wr(8'h92, 8'h70);
      @(negedge clk_i);
      chk("cap_clr", 16'h0, 16'h0, {15'h0, cirq});
    end
    // Channel 0: no edge, disabled, filtered glitch and pulse, fall, any.
    for (int j = 0; j < 6; j++) begin
      wr(8'h93, 8'(te[j]));
      wr(8'h92, tn[j] ? 8'h10 : 8'h00);
      wr(8'h94, tf[j] ? 8'h10 : 8'h00);
      m.pulse(0, tl[j]);
      xfer(8'h92, 1'b0, 8'h00, b);
      chk("chan0", 16'(tx[j]), 16'(tx[j]), {15'h0, b[0]});
    end
    test_done();
  end
endmodule // timer_capture_compare_unit_tb_top
`default_nettype wire
